// File: src/apf_cfg.svh
// Constants for the asynchronous parallel FIFO and bit-bang port.
// Assumes inclusion by bare name from every file that needs them.
`ifndef APF_CFG_SVH
`define APF_CFG_SVH

`define APF_DATA_W        8
`define APF_SYNC_N        3
`define APF_IDX_RD        0
`define APF_IDX_WR        1
`define APF_IDX_WAKE      2
`define APF_STROBE_IDLE   1'b1
`define APF_FLAG_IDLE     1'b1
`define APF_IND_IDLE      1'b1
`define APF_ACTIVE_LOW    1'b0
`define APF_PULSE_OFF     1'b0
`define APF_PULSE_ON      1'b1
`define APF_OE_OFF        1'b0
`define APF_BYTE_ZERO     8'h00
`define APF_OE_ALL        8'hff

`endif

// File: src/apf_edge_if.sv
// Carrier for synchronised strobe levels and their edge pulses.
// Assumes one clock domain shared by producer and consumer.
`timescale 1ns/1ps

interface apf_edge_if #(
    parameter int N = 3
);
    logic [N-1:0] lvl;
    logic [N-1:0] fall;
    logic [N-1:0] rise;

    modport src (output lvl, output fall, output rise);
    modport dst (input lvl, input fall, input rise);
endinterface

// File: src/apf_pkg.sv
// Types shared by the parallel port modules.
// Assumes apf_cfg.svh is on the include path.
package apf_pkg;

    typedef enum logic [1:0] {
        APF_MODE_OFF     = 2'b00,
        APF_MODE_ASYNC   = 2'b01,
        APF_MODE_BITBANG = 2'b10
    } apf_mode_t;

    typedef enum logic [1:0] {
        APF_RD_IDLE    = 2'b00,
        APF_RD_ACTIVE  = 2'b01,
        APF_RD_RECOVER = 2'b10
    } apf_rd_state_t;

    typedef enum logic [1:0] {
        APF_BB_IDLE    = 2'b00,
        APF_BB_SAMPLE  = 2'b01
    } apf_bb_state_t;

endpackage

// File: src/apf_port.sv
// Asynchronous parallel FIFO port and bit-bang port of a USB bridge.
// Assumes the receive and transmit FIFOs, USB engine and configuration
// memory live outside and talk to this block on the internal side.
`timescale 1ns/1ps
`include "apf_cfg.svh"

module apf_port #(
    parameter int DATA_W = `APF_DATA_W
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                async_fifo_cfg,
    input  wire logic                bitbang_cmd,
    input  wire logic                remote_wake_en,
    input  wire logic                rd_n,
    input  wire logic                wr_n,
    input  wire logic                send_now_wake_n,
    input  wire logic                power_enable_ind_n,
    input  wire logic [DATA_W-1:0]   bus_data_in,
    output logic      [DATA_W-1:0]   bus_data_out,
    output logic      [DATA_W-1:0]   bus_data_oe,
    output logic                     rx_ready_n,
    output logic                     rx_ready_oe,
    output logic                     tx_space_n,
    output logic                     tx_space_oe,
    input  wire logic                rx_head_valid,
    input  wire logic [DATA_W-1:0]   rx_head_data,
    output logic                     rx_pop,
    input  wire logic                tx_can_accept,
    output logic                     tx_push,
    output logic      [DATA_W-1:0]   tx_push_data,
    output logic                     resume_req,
    output logic                     flush_now,
    input  wire logic                bb_out_valid,
    input  wire logic [DATA_W-1:0]   bb_out_data,
    input  wire logic [DATA_W-1:0]   bb_dir,
    output logic                     pins_written_ind_n,
    input  wire logic                bb_sample_req,
    output logic                     pins_sampled_ind_n,
    output logic                     bb_sample_valid,
    output logic      [DATA_W-1:0]   bb_sample_data,
    output apf_pkg::apf_mode_t       active_mode
);
    import apf_pkg::*;

    apf_edge_if #(.N(`APF_SYNC_N)) edges ();

    logic [`APF_SYNC_N-1:0] strobes_n;
    apf_mode_t              mode;
    apf_mode_t              mode_ff;
    apf_rd_state_t          rd_state_ff;
    apf_bb_state_t          bb_state_ff;
    logic [DATA_W-1:0]      data_d1_ff;
    logic [DATA_W-1:0]      data_d2_ff;
    logic [DATA_W-1:0]      bus_out_ff;
    logic [DATA_W-1:0]      bus_oe_ff;
    logic                   rx_ready_n_ff;
    logic                   rx_ready_oe_ff;
    logic                   tx_space_n_ff;
    logic                   tx_space_oe_ff;
    logic                   rx_pop_ff;
    logic                   tx_push_ff;
    logic [DATA_W-1:0]      tx_push_data_ff;
    logic                   tx_hold_ff;
    logic                   resume_req_ff;
    logic                   flush_now_ff;
    logic                   pins_written_n_ff;
    logic                   pins_sampled_n_ff;
    logic                   bb_sample_valid_ff;
    logic [DATA_W-1:0]      bb_sample_data_ff;
    logic                   is_async;
    logic                   is_bitbang;
    logic                   rd_fall;
    logic                   rd_rise;
    logic                   wr_fall;
    logic                   wake_fall;

    assign strobes_n[`APF_IDX_RD]   = rd_n;
    assign strobes_n[`APF_IDX_WR]   = wr_n;
    assign strobes_n[`APF_IDX_WAKE] = send_now_wake_n;

    apf_sync_edge #(.N(`APF_SYNC_N)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (strobes_n),
        .edges    (edges)
    );

    // The host command takes the lines over even when FIFO mode is set.
    always_comb begin
        if (bitbang_cmd) begin
            mode = APF_MODE_BITBANG;
        end else if (async_fifo_cfg) begin
            mode = APF_MODE_ASYNC;
        end else begin
            mode = APF_MODE_OFF;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_ff <= APF_MODE_OFF;
        end else begin
            mode_ff <= mode;
        end
    end

    assign is_async   = (mode_ff == APF_MODE_ASYNC);
    assign is_bitbang = (mode_ff == APF_MODE_BITBANG);
    assign rd_fall    = edges.fall[`APF_IDX_RD] & is_async;
    assign rd_rise    = edges.rise[`APF_IDX_RD] & is_async;
    assign wr_fall    = edges.fall[`APF_IDX_WR] & is_async;
    assign wake_fall  = edges.fall[`APF_IDX_WAKE];

    // Bus samples are delayed to line up with the synchronised strobes.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_d1_ff <= `APF_BYTE_ZERO;
            data_d2_ff <= `APF_BYTE_ZERO;
        end else begin
            data_d1_ff <= bus_data_in;
            data_d2_ff <= data_d1_ff;
        end
    end

    // Read sequencing; RECOVER gives the FIFO head one cycle to advance.
    always_ff @(posedge ref_clk) begin
        if (reset || !is_async) begin
            rd_state_ff <= APF_RD_IDLE;
        end else begin
            case (rd_state_ff)
                APF_RD_IDLE: begin
                    if (rd_fall && !rx_ready_n_ff) begin
                        rd_state_ff <= APF_RD_ACTIVE;
                    end
                end
                APF_RD_ACTIVE: begin
                    if (rd_rise) begin
                        rd_state_ff <= APF_RD_RECOVER;
                    end
                end
                APF_RD_RECOVER: begin
                    rd_state_ff <= APF_RD_IDLE;
                end
                default: begin
                    rd_state_ff <= APF_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_pop_ff <= `APF_PULSE_OFF;
        end else begin
            rx_pop_ff <= (rd_state_ff == APF_RD_ACTIVE) && rd_rise;
        end
    end

    // Receive-ready flag.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_ready_n_ff <= `APF_FLAG_IDLE;
        end else if (!is_async || rd_rise) begin
            rx_ready_n_ff <= `APF_FLAG_IDLE;
        end else if (rd_state_ff == APF_RD_IDLE
                     && edges.lvl[`APF_IDX_RD]) begin
            rx_ready_n_ff <= !rx_head_valid;
        end
    end

    // Data bus drive for both modes.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bus_out_ff <= `APF_BYTE_ZERO;
            bus_oe_ff  <= {DATA_W{`APF_OE_OFF}};
        end else if (is_bitbang) begin
            bus_oe_ff <= bb_dir;
            if (bb_out_valid) begin
                bus_out_ff <= bb_out_data;
            end
        end else if (rd_state_ff == APF_RD_IDLE && rd_fall
                     && !rx_ready_n_ff) begin
            bus_out_ff <= rx_head_data;
            bus_oe_ff  <= `APF_OE_ALL;
        end else if (rd_rise || rd_state_ff != APF_RD_ACTIVE) begin
            bus_oe_ff <= {DATA_W{`APF_OE_OFF}};
        end
    end

    // Transmit capture on the write strobe's falling edge.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_push_ff      <= `APF_PULSE_OFF;
            tx_push_data_ff <= `APF_BYTE_ZERO;
        end else begin
            tx_push_ff <= wr_fall && !tx_space_n_ff;
            if (wr_fall && !tx_space_n_ff) begin
                tx_push_data_ff <= data_d2_ff;
            end
        end
    end

    // Transmit-space flag goes high after each write until the FIFO
    // has had a cycle to report its new fill.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_hold_ff    <= `APF_PULSE_OFF;
            tx_space_n_ff <= `APF_FLAG_IDLE;
        end else begin
            tx_hold_ff <= wr_fall;
            if (!is_async || wr_fall || tx_hold_ff || tx_push_ff) begin
                tx_space_n_ff <= `APF_FLAG_IDLE;
            end else begin
                tx_space_n_ff <= !tx_can_accept;
            end
        end
    end

    // Flags float during reset and outside FIFO mode.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_ready_oe_ff <= `APF_OE_OFF;
            tx_space_oe_ff <= `APF_OE_OFF;
        end else begin
            rx_ready_oe_ff <= is_async;
            tx_space_oe_ff <= is_async;
        end
    end

    // Send-now and wake-up share the one input in every mode.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            resume_req_ff <= `APF_PULSE_OFF;
            flush_now_ff  <= `APF_PULSE_OFF;
        end else begin
            resume_req_ff <= wake_fall && power_enable_ind_n
                             && remote_wake_en;
            flush_now_ff  <= wake_fall && !power_enable_ind_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pins_written_n_ff <= `APF_IND_IDLE;
        end else if (is_bitbang && bb_out_valid) begin
            pins_written_n_ff <= `APF_ACTIVE_LOW;
        end else begin
            pins_written_n_ff <= `APF_IND_IDLE;
        end
    end

    // Sampling: indication drops on request and rises with the capture.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bb_state_ff        <= APF_BB_IDLE;
            pins_sampled_n_ff  <= `APF_IND_IDLE;
            bb_sample_valid_ff <= `APF_PULSE_OFF;
            bb_sample_data_ff  <= `APF_BYTE_ZERO;
        end else begin
            bb_sample_valid_ff <= `APF_PULSE_OFF;
            case (bb_state_ff)
                APF_BB_IDLE: begin
                    pins_sampled_n_ff <= `APF_IND_IDLE;
                    if (is_bitbang && bb_sample_req) begin
                        pins_sampled_n_ff <= `APF_ACTIVE_LOW;
                        bb_state_ff       <= APF_BB_SAMPLE;
                    end
                end
                APF_BB_SAMPLE: begin
                    bb_sample_data_ff  <= bus_data_in;
                    bb_sample_valid_ff <= `APF_PULSE_ON;
                    pins_sampled_n_ff  <= `APF_IND_IDLE;
                    bb_state_ff        <= APF_BB_IDLE;
                end
                default: begin
                    bb_state_ff <= APF_BB_IDLE;
                end
            endcase
        end
    end

    assign bus_data_out       = bus_out_ff;
    assign bus_data_oe        = bus_oe_ff;
    assign rx_ready_n         = rx_ready_n_ff;
    assign rx_ready_oe        = rx_ready_oe_ff;
    assign tx_space_n         = tx_space_n_ff;
    assign tx_space_oe        = tx_space_oe_ff;
    assign rx_pop             = rx_pop_ff;
    assign tx_push            = tx_push_ff;
    assign tx_push_data       = tx_push_data_ff;
    assign resume_req         = resume_req_ff;
    assign flush_now          = flush_now_ff;
    assign pins_written_ind_n = pins_written_n_ff;
    assign pins_sampled_ind_n = pins_sampled_n_ff;
    assign bb_sample_valid    = bb_sample_valid_ff;
    assign bb_sample_data     = bb_sample_data_ff;
    assign active_mode        = mode_ff;

endmodule // apf_port

// File: src/apf_sync_edge.sv
// Two-flop synchronisers with edge detection for active-low strobes.
// Assumes the strobes idle high and may change at any time.
`timescale 1ns/1ps
`include "apf_cfg.svh"

module apf_sync_edge #(
    parameter int N = `APF_SYNC_N
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [N-1:0] async_in,
    apf_edge_if.src           edges
);
    import apf_pkg::*;

    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] prev_ff;

    // Only sync_ff reads meta_ff; edges look at the settled stages.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_ff <= {N{`APF_STROBE_IDLE}};
            sync_ff <= {N{`APF_STROBE_IDLE}};
            prev_ff <= {N{`APF_STROBE_IDLE}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign edges.lvl  = sync_ff;
    assign edges.fall = prev_ff & ~sync_ff;
    assign edges.rise = ~prev_ff & sync_ff;

endmodule // apf_sync_edge

// File: verif/apf_host_model.sv
// External logic on the strobe side of the parallel port.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module apf_host_model (
    input  wire logic       ref_clk,
    input  wire logic       rx_ready_n,
    input  wire logic       tx_space_n,
    input  wire logic [7:0] bus_data_out,
    input  wire logic [7:0] bus_data_oe,
    output logic            rd_n,
    output logic            wr_n,
    output logic            send_now_wake_n,
    output logic      [7:0] bus_data_in
);
    logic       drv_en = 1'b0;
    logic [7:0] drv_val = 8'h00;
    logic [7:0] last_ff = 8'h00;
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        send_now_wake_n = 1'b1;
    end
    // Undriven bits show the inverse of their last level every cycle.
    always @(posedge ref_clk) last_ff <= bus_data_in;
    assign bus_data_in = (bus_data_oe & bus_data_out)
                       | (~bus_data_oe & (drv_en ? drv_val : ~last_ff));
    task automatic read_byte(input int hold, output logic [7:0] d,
                             output bit ok);
        int n;
        for (n = 0; n < 200 && rx_ready_n !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        ok = (rx_ready_n === 1'b0);
        @(posedge ref_clk) rd_n <= 1'b0;
        repeat (hold) @(posedge ref_clk);
        #1 d = bus_data_in;
        @(posedge ref_clk) rd_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic write_byte(input int hold, input logic [7:0] d,
                              output bit ok);
        int n;
        for (n = 0; n < 200 && tx_space_n !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        ok = (tx_space_n === 1'b0);
        @(posedge ref_clk) begin
            wr_n <= 1'b0;
            drv_en <= 1'b1;
            drv_val <= d;
        end
        repeat (hold) @(posedge ref_clk);
        @(posedge ref_clk) wr_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        drv_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic wake_pulse();
        @(posedge ref_clk) send_now_wake_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        send_now_wake_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic drive_pins(input logic en, input logic [7:0] v);
        @(posedge ref_clk) begin
            drv_en <= en;
            drv_val <= v;
        end
    endtask
endmodule // apf_host_model

// File: verif/apf_port_props.sv
// Concurrent checks on the parallel port top-level ports.
// Assumes it is bound into apf_port and sees only that module's ports.
`timescale 1ns/1ps
module apf_port_props #(
    parameter int DATA_W = 8
) (
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire logic               rd_n,
    input wire logic               wr_n,
    input wire logic               send_now_wake_n,
    input wire logic               power_enable_ind_n,
    input wire logic               remote_wake_en,
    input wire logic [DATA_W-1:0]  bus_data_oe,
    input wire logic               rx_ready_n,
    input wire logic               rx_ready_oe,
    input wire logic               tx_space_n,
    input wire logic               tx_space_oe,
    input wire logic               rx_head_valid,
    input wire logic               rx_pop,
    input wire logic               tx_can_accept,
    input wire logic               tx_push,
    input wire logic               resume_req,
    input wire logic               flush_now,
    input wire logic               bb_out_valid,
    input wire logic [DATA_W-1:0]  bb_dir,
    input wire logic               pins_written_ind_n,
    input wire logic               bb_sample_req,
    input wire logic               pins_sampled_ind_n,
    input wire logic               bb_sample_valid,
    input wire apf_pkg::apf_mode_t active_mode
);
    import apf_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [3:0] rd_hi_ff;
    // Counts cycles since the read strobe was last seen low.
    always_ff @(posedge ref_clk) begin
        if (reset || !rd_n) begin
            rd_hi_ff <= 4'h0;
        end else if (rd_hi_ff != 4'hf) begin
            rd_hi_ff <= rd_hi_ff + 4'h1;
        end
    end
    sequence wr_taken;
        $fell(wr_n) && !tx_space_n && active_mode == APF_MODE_ASYNC;
    endsequence
    sequence push_late;
        !tx_push ##1 !tx_push ##[1:4] tx_push;
    endsequence
    sequence bb_req;
        bb_sample_req && pins_sampled_ind_n
            && active_mode == APF_MODE_BITBANG;
    endsequence
    a_flags_reset: assert property ($fell(reset) |-> !rx_ready_oe && !tx_space_oe)
        else $error("flag driven in reset");
    a_bus_read_only: assert property (active_mode == APF_MODE_ASYNC && $stable(active_mode) && bus_data_oe != '0 |-> rd_hi_ff < 4'h7)
        else $error("bus driven without read");
    a_rx_flag_rise: assert property (rx_pop |-> rx_ready_n ##1 rx_ready_n)
        else $error("receive flag not forced high");
    a_rx_flag_cause: assert property ($fell(rx_ready_n) |-> $past(rx_head_valid))
        else $error("receive flag low with no byte");
    a_tx_flag_cause: assert property ($fell(tx_space_n) |-> $past(tx_can_accept))
        else $error("space flag low while full");
    a_rd_pop_pair: assert property ($fell(bus_data_oe[0]) && active_mode == APF_MODE_ASYNC && $stable(active_mode) |-> rx_pop)
        else $error("read end without advance");
    a_wr_push: assert property (wr_taken |-> push_late)
        else $error("write fall not captured");
    a_wake_resume: assert property ($fell(send_now_wake_n) && power_enable_ind_n && remote_wake_en |-> ##[2:6] resume_req)
        else $error("no resume request");
    a_wake_flush: assert property ($fell(send_now_wake_n) && !power_enable_ind_n |-> ##[2:6] flush_now)
        else $error("no flush");
    a_bb_written: assert property (bb_out_valid && active_mode == APF_MODE_BITBANG |=> !pins_written_ind_n)
        else $error("no written indication");
    a_bb_sampled: assert property (bb_req |=> !pins_sampled_ind_n ##1 (pins_sampled_ind_n && bb_sample_valid))
        else $error("no sampled indication edge");
    a_bb_dir: assert property (active_mode == APF_MODE_BITBANG && $past(active_mode) == APF_MODE_BITBANG |-> bus_data_oe == $past(bb_dir))
        else $error("pin direction not followed");
endmodule // apf_port_props

bind apf_port apf_port_props #(.DATA_W(DATA_W)) u_props (.*);

// File: verif/test_apf_port.sv
// Self-checking bench for the parallel FIFO and bit-bang port.
// Assumes apf_port, its checker and apf_host_model are compiled first.
`timescale 1ns/1ps
module test_apf_port;
    import apf_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, async_fifo_cfg = 1'b1;
    logic bitbang_cmd = 1'b0, remote_wake_en = 1'b0;
    logic power_enable_ind_n = 1'b0, rx_head_valid = 1'b0;
    logic tx_can_accept = 1'b1, bb_out_valid = 1'b0, bb_sample_req = 1'b0;
    logic [7:0] rx_head_data = 8'h00, bb_out_data = 8'h00, bb_dir = 8'h00;
    logic rd_n, wr_n, send_now_wake_n, rx_ready_n, rx_ready_oe, tx_space_n;
    logic tx_space_oe, rx_pop, tx_push, resume_req, flush_now;
    logic pins_written_ind_n, pins_sampled_ind_n, bb_sample_valid;
    logic [7:0] bus_data_in, bus_data_out, bus_data_oe, tx_push_data;
    logic [7:0] bb_sample_data, b, d, dir, pv;
    apf_mode_t  active_mode;
    logic [7:0] rxq[$], rxe[$], txq[$];
    int         n_mismatch = 0, checks = 0, n_res = 0, n_flu = 0, r0, f0, i;
    bit         ok;

    apf_port dut (.*);
    apf_host_model host (.*);

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ok_or_end(input bit k);
        if (!k) begin
            n_mismatch++;
            $display("[ERR] host wait expected 1 seen 0");
            tally_and_finish();
        end
    endtask
    // Receive FIFO and transmit FIFO stand-ins on the internal side.
    always @(posedge ref_clk) begin
        if (rx_pop === 1'b1 && rxq.size() != 0) begin
            void'(rxq.pop_front());
        end
        rx_head_valid <= (rxq.size() != 0);
        rx_head_data <= (rxq.size() != 0) ? rxq[0] : 8'h00;
        if (tx_push === 1'b1) begin
            chk("tx byte", txq.size() ? txq.pop_front() : 16'hffff, tx_push_data);
        end
        n_res += (resume_req === 1'b1);
        n_flu += (flush_now === 1'b1);
    end

    initial begin
        void'($urandom(32'hf283));
        repeat (9) @(posedge ref_clk);
        #1 chk("flag oe in reset", 2'b00, {rx_ready_oe, tx_space_oe});
        @(posedge ref_clk) reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("flag oe", 2'b11, {rx_ready_oe, tx_space_oe});
        chk("flags idle", 2'b10, {rx_ready_n, tx_space_n});
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            b = 8'($urandom());
            rxq.push_back(b);
            rxe.push_back(b);
        end
        for (i = 0; i < 4; i++) begin
            host.read_byte(5 + $urandom() % 3, d, ok);
            ok_or_end(ok);
            chk("rx byte", rxe.pop_front(), d);
        end
        chk("rx flag empty", 1'b1, rx_ready_n);
        chk("bus oe idle", 8'h00, bus_data_oe);
        $display("test read done");
        for (i = 0; i < 4; i++) begin
            b = 8'($urandom());
            txq.push_back(b);
            host.write_byte(4 + $urandom() % 2, b, ok);
            ok_or_end(ok);
        end
        chk("tx left", 0, 16'(txq.size()));
        tx_can_accept <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk("tx flag full", 1'b1, tx_space_n);
        tx_can_accept <= 1'b1;
        $display("test write done");
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk) begin
                power_enable_ind_n <= i[1];
                remote_wake_en <= i[0];
            end
            r0 = n_res;
            f0 = n_flu;
            host.wake_pulse();
            chk("resume", i[1] & i[0], 16'(n_res - r0));
            chk("flush", !i[1], 16'(n_flu - f0));
        end
        $display("test wake done");
        dir = 8'($urandom());
        pv = 8'($urandom());
        @(posedge ref_clk) begin
            bitbang_cmd <= 1'b1;
            bb_dir <= dir;
        end
        host.drive_pins(1'b1, pv);
        repeat (3) @(posedge ref_clk);
        #1 chk("mode", APF_MODE_BITBANG, active_mode);
        for (i = 0; i < 3; i++) begin
            b = 8'($urandom());
            @(posedge ref_clk) begin
                bb_out_valid <= 1'b1;
                bb_out_data <= b;
            end
            @(posedge ref_clk) bb_out_valid <= 1'b0;
            #1 chk("written ind", 1'b0, pins_written_ind_n);
            chk("bb out", {dir, b}, {bus_data_oe, bus_data_out});
            @(posedge ref_clk) bb_sample_req <= 1'b1;
            @(posedge ref_clk) bb_sample_req <= 1'b0;
            #1 chk("sampled ind low", 1'b0, pins_sampled_ind_n);
            @(posedge ref_clk);
            #1 chk("sampled ind", 2'b11, {pins_sampled_ind_n, bb_sample_valid});
            chk("sample", (dir & b) | (~dir & pv), bb_sample_data);
        end
        $display("test bitbang done");
        // With neither mode chosen, the bus and both flags must float.
        @(posedge ref_clk) begin
            bitbang_cmd <= 1'b0;
            async_fifo_cfg <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        #1 chk("off mode", 16'h0000,
               {active_mode, rx_ready_oe, tx_space_oe, bus_data_oe});
        $display("test off done");
        tally_and_finish();
    end
endmodule // test_apf_port
